// ### rtl/cia_regs.vh
// Function
// - arbiter interrupt branches to supplied vector
// - supplied vector translated like any fetch
// - maskable taken only if level exceeds current
// - unmaskable request ignores both priority levels
// - switch active bank to requested bank
// - taking interrupt disables further maskable ones
// - internal controller has 32 request inputs
// - raise when allow, line and mask set
// - internal interrupt clears global allow bit
// - readable pending register shows pending lines
// - internal controller never selects shadow bank
// - trap instruction enters general exception handler
// - break instruction follows break processing
// - unimplemented instruction raises emulation exception
// - unmaskable accepted even during reset or break
`ifndef CIA_REGS_VH
`define CIA_REGS_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define CIA_OFS_STATUS   4'h0
`define CIA_OFS_MASK     4'h1
`define CIA_OFS_PENDING  4'h2
`define CIA_OFS_TAKEN    4'h3
`define CIA_OFS_CAUSE    4'h4
`define CIA_OFS_CONFIG   4'h5

// ----------------------------------------------------------------
// status fields
// ----------------------------------------------------------------
`define CIA_ST_ALLOW     0
`define CIA_ST_LVL_LO    1
`define CIA_ST_LVL_HI    6
`define CIA_ST_BANK_LO   10
`define CIA_ST_BANK_HI   15
`define CIA_ST_PBANK_LO  16
`define CIA_ST_PBANK_HI  21
`define CIA_ST_EXC       22
`define CIA_ST_BRK       23
`define CIA_ST_RSTEXC    24

// ----------------------------------------------------------------
// config fields
// ----------------------------------------------------------------
`define CIA_CFG_EXTMODE  0
`define CIA_CFG_XLATE    1
`define CIA_CFG_SHADOW   2

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define CIA_RST_STATUS   32'h01000000
`define CIA_RST_MASK     32'h00000000
`define CIA_RST_CONFIG   3'h0

// ----------------------------------------------------------------
// cause codes and vectors
// ----------------------------------------------------------------
`define CIA_CAUSE_NONE   5'h00
`define CIA_CAUSE_HWIRQ  5'h02
`define CIA_CAUSE_TRAP   5'h03
`define CIA_CAUSE_UNIMP  5'h04
`define CIA_CAUSE_BREAK  5'h1F
`define CIA_GEN_VECTOR   32'h00000020
`define CIA_BRK_VECTOR   32'h00000040

`endif

// ### rtl/cia_sync_lines.v
`timescale 1ns/1ps
module cia_sync_lines
(
	// clock and reset
	input  wire        clk,
	input  wire        resetn,
	// request lines
	input  wire [31:0] lines_in,
	input  wire [31:0] mask,
	// sampled view
	output reg  [31:0] pending,
	output reg         any_req
);

	wire [31:0] next_pending;
	genvar i;

	// ----------------------------------------------------------------
	// per line gating by mask
	// ----------------------------------------------------------------
	generate
		for (i = 0; i < 32; i = i + 1)
		begin : g_line
			assign next_pending[i] = lines_in[i] & mask[i];
		end
	endgenerate

	always @(posedge clk)
	begin
		if (!resetn)
		begin
			pending <= 32'h00000000;
			any_req <= 1'b0;
		end
		else
		begin
			pending <= next_pending;
			any_req <= |next_pending;
		end
	end

endmodule // cia_sync_lines

// ### rtl/cia_top.v
`timescale 1ns/1ps
`include "cia_regs.vh"
module cia_top
(
	// clock and reset
	input  wire        CLK,
	input  wire        RESETN,
	// register port
	input  wire [3:0]  REG_ADDR,
	input  wire [31:0] REG_WDATA,
	input  wire        REG_WR,
	input  wire        REG_RD,
	output reg  [31:0] REG_RDATA,
	// internal controller request lines
	input  wire [31:0] REQUEST_LINES,
	// outside arbiter
	input  wire        ARB_REQ,
	input  wire [31:0] HANDLER_VECTOR_REQUEST,
	input  wire [5:0]  REQUESTED_PRIORITY_LEVEL,
	input  wire [5:0]  REQUESTED_SHADOW_BANK,
	input  wire        UNMASKABLE_REQUEST_FLAG,
	// pipeline
	input  wire        INSTR_BOUNDARY,
	input  wire        TRAP_EXEC,
	input  wire        BREAK_EXEC,
	input  wire        UNIMP_EXEC,
	input  wire        HW_BREAK,
	input  wire        EXC_RETURN,
	// redirect
	output reg         TAKE,
	output reg  [31:0] TARGET_PC,
	output reg         TARGET_VIRTUAL,
	output reg  [4:0]  CAUSE,
	output reg  [5:0]  ACTIVE_BANK,
	output reg         ARB_ACK
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	reg  [31:0] status;
	reg  [31:0] mask;
	reg  [2:0]  config_bits;
	reg  [31:0] taken_count;
	reg         arb_req;
	reg  [31:0] arb_vec;
	reg  [5:0]  arb_lvl;
	reg  [5:0]  arb_bank;
	reg         arb_nmi;
	wire [31:0] pending;
	wire        any_req;

	wire        allow     = status[`CIA_ST_ALLOW];
	wire [5:0]  cur_lvl   = status[`CIA_ST_LVL_HI:`CIA_ST_LVL_LO];
	wire [5:0]  cur_bank  = status[`CIA_ST_BANK_HI:`CIA_ST_BANK_LO];
	wire        ext_mode  = config_bits[`CIA_CFG_EXTMODE];
	wire        shadow_on = config_bits[`CIA_CFG_SHADOW];

	// ----------------------------------------------------------------
	// register write decode
	// ----------------------------------------------------------------
	wire        wr_status = REG_WR & (REG_ADDR == `CIA_OFS_STATUS);
	wire        wr_mask   = REG_WR & (REG_ADDR == `CIA_OFS_MASK);
	wire        wr_config = REG_WR & (REG_ADDR == `CIA_OFS_CONFIG);

	// ----------------------------------------------------------------
	// internal controller lines
	// ----------------------------------------------------------------
	cia_sync_lines u_lines
	(
		.clk      (CLK),
		.resetn   (RESETN),
		.lines_in (REQUEST_LINES),
		.mask     (mask),
		.pending  (pending),
		.any_req  (any_req)
	);

	// ----------------------------------------------------------------
	// outside arbiter capture
	// ----------------------------------------------------------------
	always @(posedge CLK)
	begin
		if (!RESETN)
		begin
			arb_req  <= 1'b0;
			arb_vec  <= 32'h00000000;
			arb_lvl  <= 6'h00;
			arb_bank <= 6'h00;
			arb_nmi  <= 1'b0;
		end
		else
		begin
			arb_req  <= ARB_REQ;
			// fields only meaningful beside a request
			if (ARB_REQ)
			begin
				arb_vec  <= HANDLER_VECTOR_REQUEST;
				arb_lvl  <= REQUESTED_PRIORITY_LEVEL;
				arb_bank <= REQUESTED_SHADOW_BANK;
				arb_nmi  <= UNMASKABLE_REQUEST_FLAG;
			end
		end
	end

	// ----------------------------------------------------------------
	// take decision
	// ----------------------------------------------------------------
	wire ext_nmi  = ext_mode & arb_req & arb_nmi;
	wire ext_mask = ext_mode & arb_req & ~arb_nmi & allow
		& (arb_lvl > cur_lvl);
	wire int_irq  = ~ext_mode & allow & any_req;
	wire ext_take = ext_nmi | ext_mask;

	reg  [31:0] next_status;
	reg         next_take;
	reg  [31:0] next_target;
	reg         next_virtual;
	reg  [4:0]  next_cause;
	reg  [2:0]  next_src;

	// ----------------------------------------------------------------
	// source select, highest priority first
	// ----------------------------------------------------------------
	localparam SRC_NONE  = 3'h0;
	localparam SRC_BREAK = 3'h1;
	localparam SRC_ARB   = 3'h2;
	localparam SRC_INT   = 3'h3;
	localparam SRC_TRAP  = 3'h4;
	localparam SRC_UNIMP = 3'h5;

	always @*
	begin
		next_src = SRC_NONE;
		if (INSTR_BOUNDARY)
		begin
			if (BREAK_EXEC || HW_BREAK)
				next_src = SRC_BREAK;
			else if (ext_take)
				next_src = SRC_ARB;
			else if (int_irq)
				next_src = SRC_INT;
			else if (TRAP_EXEC)
				next_src = SRC_TRAP;
			else if (UNIMP_EXEC)
				next_src = SRC_UNIMP;
		end
	end

	// ----------------------------------------------------------------
	// status update and redirect
	// ----------------------------------------------------------------
	always @*
	begin
		next_status  = status;
		next_take    = 1'b0;
		next_target  = TARGET_PC;
		next_virtual = 1'b0;
		next_cause   = CAUSE;
		// software write, a take below overrides the fields it sets
		if (wr_status)
			next_status = REG_WDATA;
		// return clears exception flags only
		if (EXC_RETURN)
		begin
			next_status[`CIA_ST_EXC] = 1'b0;
			next_status[`CIA_ST_BRK] = 1'b0;
			next_status[`CIA_ST_RSTEXC] = 1'b0;
		end
		case (next_src)
			SRC_BREAK:
			begin
				next_take   = 1'b1;
				next_target = `CIA_BRK_VECTOR;
				next_cause  = `CIA_CAUSE_BREAK;
				next_status[`CIA_ST_ALLOW] = 1'b0;
				next_status[`CIA_ST_BRK] = 1'b1;
				next_status[`CIA_ST_PBANK_HI:`CIA_ST_PBANK_LO] = cur_bank;
				next_status[`CIA_ST_BANK_HI:`CIA_ST_BANK_LO] = 6'h00;
			end
			SRC_ARB:
			begin
				next_take    = 1'b1;
				next_target  = arb_vec;
				next_virtual = config_bits[`CIA_CFG_XLATE];
				next_cause   = `CIA_CAUSE_HWIRQ;
				next_status[`CIA_ST_ALLOW] = 1'b0;
				// unmaskable entry keeps the current level
				if (!arb_nmi)
					next_status[`CIA_ST_LVL_HI:`CIA_ST_LVL_LO] = arb_lvl;
				next_status[`CIA_ST_PBANK_HI:`CIA_ST_PBANK_LO] = cur_bank;
				if (shadow_on)
					next_status[`CIA_ST_BANK_HI:`CIA_ST_BANK_LO] = arb_bank;
			end
			SRC_INT:
			begin
				// no bank choice on internal entry
				next_take   = 1'b1;
				next_target = `CIA_GEN_VECTOR;
				next_cause  = `CIA_CAUSE_HWIRQ;
				next_status[`CIA_ST_ALLOW] = 1'b0;
				next_status[`CIA_ST_PBANK_HI:`CIA_ST_PBANK_LO] = cur_bank;
				next_status[`CIA_ST_BANK_HI:`CIA_ST_BANK_LO] = cur_bank;
			end
			SRC_TRAP:
			begin
				next_take   = 1'b1;
				next_target = `CIA_GEN_VECTOR;
				next_cause  = `CIA_CAUSE_TRAP;
				next_status[`CIA_ST_ALLOW] = 1'b0;
				next_status[`CIA_ST_EXC] = 1'b1;
				next_status[`CIA_ST_PBANK_HI:`CIA_ST_PBANK_LO] = cur_bank;
				next_status[`CIA_ST_BANK_HI:`CIA_ST_BANK_LO] = 6'h00;
			end
			SRC_UNIMP:
			begin
				next_take   = 1'b1;
				next_target = `CIA_GEN_VECTOR;
				next_cause  = `CIA_CAUSE_UNIMP;
				next_status[`CIA_ST_ALLOW] = 1'b0;
				next_status[`CIA_ST_EXC] = 1'b1;
				next_status[`CIA_ST_PBANK_HI:`CIA_ST_PBANK_LO] = cur_bank;
				next_status[`CIA_ST_BANK_HI:`CIA_ST_BANK_LO] = 6'h00;
			end
			default:
			begin
				next_virtual = 1'b0;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// internal registers
	// ----------------------------------------------------------------
	always @(posedge CLK)
	begin
		if (!RESETN)
		begin
			status         <= `CIA_RST_STATUS;
			mask           <= `CIA_RST_MASK;
			config_bits    <= `CIA_RST_CONFIG;
			taken_count    <= 32'h00000000;
		end
		else
		begin
			status         <= next_status;
			if (next_take)
				taken_count <= taken_count + 32'h00000001;
			if (wr_mask)
				mask <= REG_WDATA;
			if (wr_config)
				config_bits <= REG_WDATA[2:0];
		end
	end

	// ----------------------------------------------------------------
	// redirect outputs
	// ----------------------------------------------------------------
	always @(posedge CLK)
	begin
		if (!RESETN)
		begin
			TAKE           <= 1'b0;
			TARGET_PC      <= 32'h00000000;
			TARGET_VIRTUAL <= 1'b0;
			CAUSE          <= `CIA_CAUSE_NONE;
			ACTIVE_BANK    <= 6'h00;
			ARB_ACK        <= 1'b0;
		end
		else
		begin
			TAKE           <= next_take;
			TARGET_PC      <= next_target;
			TARGET_VIRTUAL <= next_virtual;
			CAUSE          <= next_cause;
			ACTIVE_BANK    <= next_status[`CIA_ST_BANK_HI:`CIA_ST_BANK_LO];
			ARB_ACK        <= (next_src == SRC_ARB);
		end
	end

	// ----------------------------------------------------------------
	// register read, data one cycle after strobe
	// ----------------------------------------------------------------
	reg  [31:0] next_rdata;

	always @*
	begin
		next_rdata = 32'h00000000;
		if (REG_RD)
		begin
			case (REG_ADDR)
				`CIA_OFS_STATUS:  next_rdata = status;
				`CIA_OFS_MASK:    next_rdata = mask;
				`CIA_OFS_PENDING: next_rdata = pending;
				`CIA_OFS_TAKEN:   next_rdata = taken_count;
				`CIA_OFS_CAUSE:   next_rdata = {27'h0000000, CAUSE};
				`CIA_OFS_CONFIG:  next_rdata = {29'h00000000, config_bits};
				default:          next_rdata = 32'h00000000;
			endcase
		end
	end

	always @(posedge CLK)
	begin
		if (!RESETN)
			REG_RDATA <= 32'h00000000;
		else
			REG_RDATA <= next_rdata;
	end

endmodule // cia_top

// ### sim/cia_props.sv
`timescale 1ns/1ps
module cia_props
(
	// clock and reset
	input wire        CLK,
	input wire        RESETN,
	// register port
	input wire        REG_RD,
	input wire [31:0] REG_RDATA,
	// requests
	input wire [31:0] REQUEST_LINES,
	input wire        ARB_REQ,
	input wire [31:0] HANDLER_VECTOR_REQUEST,
	input wire        INSTR_BOUNDARY,
	input wire        TRAP_EXEC,
	input wire        BREAK_EXEC,
	input wire        UNIMP_EXEC,
	input wire        HW_BREAK,
	// redirect
	input wire        TAKE,
	input wire [31:0] TARGET_PC,
	input wire        TARGET_VIRTUAL,
	input wire [4:0]  CAUSE,
	input wire        ARB_ACK
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RESETN);
	wire exc_in = TRAP_EXEC | BREAK_EXEC | UNIMP_EXEC | HW_BREAK;
	property p_bnd; TAKE |-> $past(INSTR_BOUNDARY); endproperty
	a_bnd: assert property (p_bnd) else $error("take off boundary");
	property p_src;
		TAKE |-> $past(exc_in) || $past(ARB_REQ, 2) || $past(REQUEST_LINES, 2) != 32'h0;
	endproperty
	a_src: assert property (p_src) else $error("take without cause");
	property p_vec;
		ARB_ACK |-> TAKE && CAUSE == 5'h02 && TARGET_PC == $past(HANDLER_VECTOR_REQUEST, 2);
	endproperty
	a_vec: assert property (p_vec) else $error("bad arbiter vector");
	property p_virt; TARGET_VIRTUAL |-> TAKE; endproperty
	a_virt: assert property (p_virt) else $error("stray virtual flag");
	property p_brk; TAKE && CAUSE == 5'h1F |-> TARGET_PC == 32'h40; endproperty
	a_brk: assert property (p_brk) else $error("bad break vector");
	property p_gen;
		TAKE && !ARB_ACK && CAUSE != 5'h1F |-> TARGET_PC == 32'h20;
	endproperty
	a_gen: assert property (p_gen) else $error("bad general vector");
	property p_held; !TAKE |-> $stable(CAUSE) && $stable(TARGET_PC); endproperty
	a_held: assert property (p_held) else $error("redirect moved");
	property p_rd; !$past(REG_RD) |-> REG_RDATA == 32'h0; endproperty
	a_rd: assert property (p_rd) else $error("read data not idle");
	c_arb: cover property (ARB_ACK);
	c_brk: cover property (TAKE && CAUSE == 5'h1F);
	c_int: cover property (TAKE && !ARB_ACK && CAUSE == 5'h02);
endmodule // cia_props
bind cia_top cia_props i_props (.*);

// ### sim/cia_arb_model.sv
`timescale 1ns/1ps
module cia_arb_model
(
	// command
	input wire        clk,
	input wire        go,
	input wire [31:0] vec,
	input wire [5:0]  lvl,
	input wire [5:0]  bank,
	input wire        nmi,
	// toward the core
	output reg        req = 1'b0,
	output reg [31:0] hv = 32'h0,
	output reg [5:0]  rl = 6'h0,
	output reg [5:0]  rb = 6'h0,
	output reg        un = 1'b0
);
	// fields scrambled while no request stands
	always @(posedge clk)
	begin
		req <= go;
		hv <= go ? vec : ~hv;
		rl <= go ? lvl : ~rl;
		rb <= go ? bank : ~rb;
		un <= go ? nmi : ~un;
	end
endmodule // cia_arb_model

// ### sim/tb_cpu_interrupt_acceptance.sv
`timescale 1ns/1ps
module tb_cpu_interrupt_acceptance;
	reg clk = 0, rstn = 0, wr = 0, rd = 0, ib = 0, eret = 0, go = 0, nmi = 0;
	reg [3:0] addr = 0, ex = 0;
	reg [31:0] wdata = 0, lines = 0, vec = 0;
	reg [5:0] lvl = 0, bank = 0;
	wire [31:0] rdata, hv, pc;
	wire [5:0] rl, rb, abank;
	wire [4:0] cause;
	wire req, un, take, virt, ack;
	integer failures = 0, num_checks = 0, i;
	always #4 clk = ~clk;
	cia_arb_model i_arb (.clk(clk), .go(go), .vec(vec), .lvl(lvl), .bank(bank), .nmi(nmi),
		.req(req), .hv(hv), .rl(rl), .rb(rb), .un(un));
	cia_top i_dut (.CLK(clk), .RESETN(rstn), .REG_ADDR(addr), .REG_WDATA(wdata),
		.REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .REQUEST_LINES(lines),
		.ARB_REQ(req), .HANDLER_VECTOR_REQUEST(hv), .REQUESTED_PRIORITY_LEVEL(rl),
		.REQUESTED_SHADOW_BANK(rb), .UNMASKABLE_REQUEST_FLAG(un), .INSTR_BOUNDARY(ib),
		.TRAP_EXEC(ex[0]), .BREAK_EXEC(ex[1]), .UNIMP_EXEC(ex[2]), .HW_BREAK(ex[3]),
		.EXC_RETURN(eret), .TAKE(take), .TARGET_PC(pc), .TARGET_VIRTUAL(virt),
		.CAUSE(cause), .ACTIVE_BANK(abank), .ARB_ACK(ack));
	task chk(input [31:0] got, input [31:0] exp);
	begin
		num_checks = num_checks + 1;
		if (got !== exp)
		begin
			failures = failures + 1;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	end
	endtask
	task wr_reg(input [3:0] a, input [31:0] d);
	begin
		@(posedge clk); addr <= a; wdata <= d; wr <= 1'b1;
		@(posedge clk); wr <= 1'b0;
	end
	endtask
	task rd_reg(input [3:0] a, input [31:0] m, input [31:0] e);
	begin
		@(posedge clk); addr <= a; rd <= 1'b1;
		@(posedge clk); rd <= 1'b0;
		#1 chk(rdata & m, e);
	end
	endtask
	// decision cycle, then look at the redirect
	task step(input [3:0] x, input t, input [4:0] c, input [31:0] p);
	begin
		repeat (3) @(posedge clk);
		ib <= 1'b1; ex <= x;
		@(posedge clk); ib <= 1'b0; ex <= 4'h0;
		#1 chk(take, t);
		if (t)
		begin
			chk(cause, c);
			chk(pc, p);
		end
	end
	endtask
	task finish_test;
	begin
		$display("checks=%0d failures=%0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	end
	endtask
	initial
	begin
		#20000 failures = failures + 1;
		finish_test;
	end
	initial
	begin
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		rd_reg(4'h0, 32'hFFFFFFFF, 32'h01000000);
		rd_reg(4'h5, 32'h7, 32'h0);
		rd_reg(4'hF, 32'hFFFFFFFF, 32'h0);
		wr_reg(4'h1, 32'h80000020);
		wr_reg(4'h0, 32'h00000C01);
		lines <= 32'h00000120;
		step(4'h0, 1, 5'h02, 32'h20);
		chk(abank, 6'h3);
		rd_reg(4'h2, 32'hFFFFFFFF, 32'h20);
		rd_reg(4'h0, 32'h1, 32'h0);
		step(4'h0, 0, 0, 0);
		lines <= 32'h80000100;
		wr_reg(4'h0, 32'h1);
		step(4'h0, 1, 5'h02, 32'h20);
		lines <= 32'h00000100;
		wr_reg(4'h0, 32'h1);
		step(4'h0, 0, 0, 0);
		lines <= 32'h0;
		for (i = 0; i < 4; i = i + 1)
			step(4'h1 << i, 1, i == 0 ? 5'h03 : i == 2 ? 5'h04 : 5'h1F,
				i[0] ? 32'h40 : 32'h20);
		wr_reg(4'h5, 32'h7);
		vec <= 32'h1000; bank <= 6'h5; nmi <= 1'b1; go <= 1'b1;
		step(4'h0, 1, 5'h02, 32'h1000);
		chk(ack, 1);
		chk(virt, 1);
		chk(abank, 6'h5);
		go <= 1'b0;
		@(posedge clk); eret <= 1'b1;
		@(posedge clk); eret <= 1'b0;
		wr_reg(4'h0, 32'h7);
		vec <= 32'h2000; lvl <= 6'h3; bank <= 6'h2; nmi <= 1'b0; go <= 1'b1;
		step(4'h0, 0, 0, 0);
		lvl <= 6'h4;
		step(4'h0, 1, 5'h02, 32'h2000);
		chk(abank, 6'h2);
		rd_reg(4'h0, 32'h7F, 32'h08);
		rd_reg(4'h3, 32'hFFFFFFFF, 32'h8);
		rd_reg(4'h4, 32'h1F, 32'h02);
		go <= 1'b0;
		finish_test;
	end
endmodule // tb_cpu_interrupt_acceptance
